// [design/cmp_misc_pkg.sv]
// Package: register map, field positions and carrier types for the comparator and power control bank
package cmp_misc_pkg;

    localparam int ADDR_W = 12;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] OFF_CMP_CTRL  = 12'h00c;
    localparam logic [ADDR_W-1:0] OFF_MISC_CTRL = 12'h010;
    localparam logic [ADDR_W-1:0] OFF_INT_STAT  = 12'h040;
    localparam logic [ADDR_W-1:0] OFF_INT_MASK  = 12'h044;

    // comparator_control fields
    localparam int CMP_EN_BIT   = 0;
    localparam int CMP_POL_BIT  = 5;
    localparam int CMP_IE_BIT   = 6;
    localparam int CMP_OUT_BIT  = 14;
    localparam int CMP_FLAG_BIT = 15;

    // misc_power_control fields
    localparam int MISC_NRO_BIT   = 2;
    localparam int MISC_XTAL_BIT  = 3;
    localparam int MISC_DNM_LSB   = 4;
    localparam int MISC_SCALE_BIT = 8;
    localparam int MISC_HOLD_BIT  = 9;
    localparam logic [3:0] MISC_DNM_RST = 4'h1;

    // Interrupt status / mask fields
    localparam int IRQ_EDGE_BIT = 0;
    localparam int IRQ_W        = 1;

    // Control to the analog side
    typedef struct packed {
        logic cmp_on;
        logic reg_rst_hold;
        logic reg_clk_scale;
        logic xtal_keep;
        logic nro_keep;
    } ana_ctrl_t;

    // Power events from the power manager
    typedef struct packed {
        logic por;
        logic sys_rst;
        logic lp_exit;
    } pwr_evt_t;

endpackage

// [design/cmp_edge_detect.sv]
// Comparator output synchroniser and selected-edge detector
`timescale 1ns/10ps
module cmp_edge_detect (
    input  wire logic pclk,      // Bus clock
    input  wire logic presetn,   // Async reset, active low
    input  wire logic cmp_raw,   // Asynchronous comparator output
    input  wire logic enable,    // Comparator on
    input  wire logic fall_sel,  // 0 rise, 1 fall
    output logic      level,     // Synchronised level
    output logic      hit        // One-cycle pulse on chosen edge
);

    logic s1_r, s2_r, s3_r;
    logic s1_nxt, s2_nxt, s3_nxt;

    // Two-flop synchroniser then history stage
    always_comb begin
        s1_nxt = cmp_raw;
        s2_nxt = s1_r;
        s3_nxt = s2_r;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
            s3_r <= 1'b0;
        end else begin
            s1_r <= s1_nxt;
            s2_r <= s2_nxt;
            s3_r <= s3_nxt;
        end
    end

    // Edge chosen by polarity; off comparator produces no events
    assign level = s2_r;
    assign hit   = enable & (fall_sel ? (s3_r & ~s2_r) : (~s3_r & s2_r));

endmodule

// [design/cmp_misc_regs.sv]
// APB register bank for comparator control and miscellaneous power control
// Operation
// - Flag bit 15 sets on the comparator edge chosen by polarity.
// - Writing one clears the flag; zero leaves it; reads show it.
// - Read-only bit 14 shows the present comparator output level.
// - Bit 6 enables the comparator interrupt; resets to zero.
// - Bit 5 selects edge: zero rising, one falling.
// - Bit 0 switches the comparator on; resets to zero.
// - Bit 9 set: regulator reset only by power-on reset.
// - Bit 9 set: regulator setpoints kept on low-power exit.
// - Bit 8 enables regulator clock scaling at low load.
// - Bit 3 keeps the crystal oscillator on in low-power states.
// - All fields return to reset values on presetn; power-on and system reset events leave them.
//
// The APB register port was chosen for this implementation.
`timescale 1ns/10ps
module cmp_misc_regs
    import cmp_misc_pkg::*;
(
    input  wire logic              pclk,          // APB clock, 40 MHz
    input  wire logic              presetn,       // Async reset, active low
    input  wire logic              psel,          // APB select
    input  wire logic              penable,       // APB enable
    input  wire logic              pwrite,        // APB write
    input  wire logic [ADDR_W-1:0] paddr,         // APB byte address
    input  wire logic [31:0]       pwdata,        // APB write data
    input  wire logic [3:0]        pstrb,         // APB byte strobes
    output logic      [31:0]       prdata,        // APB read data
    output logic                   pready,        // APB ready
    output logic                   pslverr,       // APB error
    input  wire logic              cmp_raw,       // Comparator output, async
    input  wire pwr_evt_t          pwr_evt,       // Power events, pclk domain
    output ana_ctrl_t              ana_ctrl,      // Analog control
    output logic                   reg_rst,       // Regulator reset pulse
    output logic                   setpoint_load, // Reload voltage_setpoint pulse
    output logic                   cmp_irq,       // Comparator interrupt request
    output logic                   irq            // Masked summary interrupt
);

    // ----------------------------------------------------------------
    // Register state
    // ----------------------------------------------------------------
    logic       cmp_en_r, cmp_pol_r, cmp_ie_r, cmp_flag_r;
    logic       cmp_en_nxt, cmp_pol_nxt, cmp_ie_nxt, cmp_flag_nxt;
    logic       hold_r, scale_r, xtal_r, nro_r;
    logic       hold_nxt, scale_nxt, xtal_nxt, nro_nxt;
    logic [3:0] dnm_r, dnm_nxt;
    logic [IRQ_W-1:0] stat_r, stat_nxt, mask_r, mask_nxt;
    logic [31:0] prdata_r, prdata_nxt;
    logic       pslverr_r, pslverr_nxt, pready_r, pready_nxt;
    ana_ctrl_t  ana_r, ana_nxt;
    logic       reg_rst_r, reg_rst_nxt, sp_load_r, sp_load_nxt;
    logic       cmp_irq_r, cmp_irq_nxt, irq_r, irq_nxt;

    logic       cmp_level, cmp_hit;
    logic       wr_acc, rd_acc, mapped;

    // Synchroniser and edge detector
    cmp_edge_detect u_edge (
        .pclk     (pclk),
        .presetn  (presetn),
        .cmp_raw  (cmp_raw),
        .enable   (cmp_en_r),
        .fall_sel (cmp_pol_r),
        .level    (cmp_level),
        .hit      (cmp_hit)
    );

    // ----------------------------------------------------------------
    // APB decode
    // ----------------------------------------------------------------
    // Setup cycle starts an access; answer in access phase one cycle later
    function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
        return (a == OFF_CMP_CTRL) || (a == OFF_MISC_CTRL) ||
               (a == OFF_INT_STAT) || (a == OFF_INT_MASK);
    endfunction

    assign mapped = is_mapped(paddr);
    assign wr_acc = psel & penable & pready_r & pwrite & mapped & pstrb[0] & pstrb[1];
    assign rd_acc = psel & ~penable & ~pwrite;

    // Bus answer: ready one cycle after setup, error for unmapped address
    always_comb begin
        pready_nxt  = psel & ~penable;
        pslverr_nxt = psel & ~penable & ~is_mapped(paddr);
        prdata_nxt  = prdata_r;
        if (rd_acc) begin
            prdata_nxt = 32'h0000_0000;
            unique case (paddr)
                OFF_CMP_CTRL: begin
                    prdata_nxt[CMP_FLAG_BIT] = cmp_flag_r;
                    prdata_nxt[CMP_OUT_BIT]  = cmp_level;
                    prdata_nxt[CMP_IE_BIT]   = cmp_ie_r;
                    prdata_nxt[CMP_POL_BIT]  = cmp_pol_r;
                    prdata_nxt[CMP_EN_BIT]   = cmp_en_r;
                end
                OFF_MISC_CTRL: begin
                    prdata_nxt[MISC_HOLD_BIT]  = hold_r;
                    prdata_nxt[MISC_SCALE_BIT] = scale_r;
                    prdata_nxt[MISC_DNM_LSB +: 4] = dnm_r;
                    prdata_nxt[MISC_XTAL_BIT]  = xtal_r;
                    prdata_nxt[MISC_NRO_BIT]   = nro_r;
                end
                OFF_INT_STAT: prdata_nxt[IRQ_W-1:0] = stat_r;
                OFF_INT_MASK: prdata_nxt[IRQ_W-1:0] = mask_r;
                default:      prdata_nxt = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= 32'h0000_0000;
        end else begin
            pready_r  <= pready_nxt;
            pslverr_r <= pslverr_nxt;
            prdata_r  <= prdata_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Comparator control register
    // ----------------------------------------------------------------
    // Writes need the low two byte lanes; event set beats a same-cycle clear
    always_comb begin
        cmp_en_nxt   = cmp_en_r;
        cmp_pol_nxt  = cmp_pol_r;
        cmp_ie_nxt   = cmp_ie_r;
        cmp_flag_nxt = cmp_flag_r;
        if (wr_acc && paddr == OFF_CMP_CTRL) begin
            cmp_en_nxt  = pwdata[CMP_EN_BIT];
            cmp_pol_nxt = pwdata[CMP_POL_BIT];
            cmp_ie_nxt  = pwdata[CMP_IE_BIT];
            if (pwdata[CMP_FLAG_BIT])
                cmp_flag_nxt = 1'b0;
        end
        if (cmp_hit)
            cmp_flag_nxt = 1'b1;
    end

    // Reset returns every field to its reset value
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmp_en_r   <= 1'b0;
            cmp_pol_r  <= 1'b0;
            cmp_ie_r   <= 1'b0;
            cmp_flag_r <= 1'b0;
        end else begin
            cmp_en_r   <= cmp_en_nxt;
            cmp_pol_r  <= cmp_pol_nxt;
            cmp_ie_r   <= cmp_ie_nxt;
            cmp_flag_r <= cmp_flag_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Miscellaneous power control register
    // ----------------------------------------------------------------
    // Do-not-modify field keeps its reset pattern; writes ignore it
    always_comb begin
        hold_nxt  = hold_r;
        scale_nxt = scale_r;
        xtal_nxt  = xtal_r;
        nro_nxt   = nro_r;
        dnm_nxt   = dnm_r;
        if (wr_acc && paddr == OFF_MISC_CTRL) begin
            hold_nxt  = pwdata[MISC_HOLD_BIT];
            scale_nxt = pwdata[MISC_SCALE_BIT];
            xtal_nxt  = pwdata[MISC_XTAL_BIT];
            nro_nxt   = pwdata[MISC_NRO_BIT];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hold_r  <= 1'b0;
            scale_r <= 1'b0;
            xtal_r  <= 1'b0;
            nro_r   <= 1'b0;
            dnm_r   <= MISC_DNM_RST;
        end else begin
            hold_r  <= hold_nxt;
            scale_r <= scale_nxt;
            xtal_r  <= xtal_nxt;
            nro_r   <= nro_nxt;
            dnm_r   <= dnm_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Interrupt status and mask
    // ----------------------------------------------------------------
    // Sticky edge status, write one to clear, set wins
    always_comb begin
        stat_nxt = stat_r;
        mask_nxt = mask_r;
        if (wr_acc && paddr == OFF_INT_STAT)
            stat_nxt = stat_r & ~pwdata[IRQ_W-1:0];
        if (wr_acc && paddr == OFF_INT_MASK)
            mask_nxt = pwdata[IRQ_W-1:0];
        if (cmp_hit)
            stat_nxt[IRQ_EDGE_BIT] = 1'b1;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stat_r <= '0;
            mask_r <= '0;
        end else begin
            stat_r <= stat_nxt;
            mask_r <= mask_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Outputs to analog side and interrupt lines
    // ----------------------------------------------------------------
    // Regulator reset on system reset only when hold is clear; setpoints
    // reload on low-power exit only when hold is clear
    always_comb begin
        ana_nxt.cmp_on        = cmp_en_nxt;
        ana_nxt.reg_rst_hold  = hold_nxt;
        ana_nxt.reg_clk_scale = scale_nxt;
        ana_nxt.xtal_keep     = xtal_nxt;
        ana_nxt.nro_keep      = nro_nxt;
        reg_rst_nxt = pwr_evt.por | (pwr_evt.sys_rst & ~hold_r);
        sp_load_nxt = pwr_evt.lp_exit & ~hold_r;
        cmp_irq_nxt = cmp_flag_nxt & cmp_ie_nxt;
        irq_nxt     = |(stat_nxt & mask_nxt);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ana_r     <= '0;
            reg_rst_r <= 1'b0;
            sp_load_r <= 1'b0;
            cmp_irq_r <= 1'b0;
            irq_r     <= 1'b0;
        end else begin
            ana_r     <= ana_nxt;
            reg_rst_r <= reg_rst_nxt;
            sp_load_r <= sp_load_nxt;
            cmp_irq_r <= cmp_irq_nxt;
            irq_r     <= irq_nxt;
        end
    end

    assign prdata        = prdata_r;
    assign pready        = pready_r;
    assign pslverr       = pslverr_r;
    assign ana_ctrl      = ana_r;
    assign reg_rst       = reg_rst_r;
    assign setpoint_load = sp_load_r;
    assign cmp_irq       = cmp_irq_r;
    assign irq           = irq_r;

endmodule

// [tb/cmp_misc_regs_assertions.sv]
// Assertion checker for the comparator and power control bank
`timescale 1ns/10ps
module cmp_misc_regs_assertions
    import cmp_misc_pkg::*;
(
    input wire logic              pclk,         // Clock
    input wire logic              presetn,      // Reset, active low
    input wire logic              psel,         // Select
    input wire logic              penable,      // Enable
    input wire logic              pwrite,       // Write
    input wire logic [ADDR_W-1:0] paddr,        // Address
    input wire logic [31:0]       pwdata,       // Write data
    input wire logic [3:0]        pstrb,        // Strobes
    input wire logic              pready,       // Ready
    input wire pwr_evt_t          pwr_evt,      // Power events
    input wire ana_ctrl_t         ana_ctrl,     // Analog controls
    input wire logic              reg_rst,      // Regulator reset
    input wire logic              setpoint_load // Setpoint reload
);
    logic wr;
    logic wc;
    logic wm;
    // Committed writes, and those to the two control registers
    assign wr = psel && penable && pready && pwrite && pstrb[1:0] == 2'b11;
    assign wc = wr && paddr == OFF_CMP_CTRL;
    assign wm = wr && paddr == OFF_MISC_CTRL;
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    cmp_on_a: assert property (wc |-> ##2 ana_ctrl.cmp_on == $past(pwdata[0], 2))
        else $error("comparator enable not applied");
    hold_wr_a: assert property (wm |-> ##2 ana_ctrl.reg_rst_hold == $past(pwdata[9], 2))
        else $error("reset hold not applied");
    scale_wr_a: assert property (wm |-> ##2 ana_ctrl.reg_clk_scale == $past(pwdata[8], 2))
        else $error("clock scaling not applied");
    xtal_wr_a: assert property (wm |-> ##2 ana_ctrl.xtal_keep == $past(pwdata[3], 2))
        else $error("crystal keep not applied");
    nro_wr_a: assert property (wm |-> ##2 ana_ctrl.nro_keep == $past(pwdata[2], 2))
        else $error("ring oscillator keep not applied");
    por_rst_a: assert property (pwr_evt.por |=> reg_rst)
        else $error("power-on reset did not reset regulator");
    sys_rst_a: assert property (pwr_evt.sys_rst && !pwr_evt.por && !$past(wm) &&
        $stable(ana_ctrl.reg_rst_hold) |=> reg_rst != $past(ana_ctrl.reg_rst_hold))
        else $error("system reset of regulator wrong");
    lp_hold_a: assert property (pwr_evt.lp_exit && !$past(wm) &&
        $stable(ana_ctrl.reg_rst_hold) |=> setpoint_load != $past(ana_ctrl.reg_rst_hold))
        else $error("setpoint reload wrong");
endmodule

bind cmp_misc_regs cmp_misc_regs_assertions u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb, .pready, .pwr_evt, .ana_ctrl, .reg_rst, .setpoint_load);

// [tb/analog_partner.sv]
// Model of the comparator stage and the power manager
`timescale 1ns/10ps
module analog_partner
    import cmp_misc_pkg::*;
(
    input  wire logic pclk,    // Bus clock
    output logic      cmp_raw, // Comparator output
    output pwr_evt_t  pwr_evt  // Power events
);
    // Quiet start
    initial begin
        cmp_raw = 1'b0;
        pwr_evt = '0;
    end
    // Analog output moves off the clock grid
    task automatic set_level(input logic v);
        #7 cmp_raw = v;
    endtask
    // One-cycle event pulse launched after a rising edge
    task automatic pulse(input pwr_evt_t e);
        @(posedge pclk);
        pwr_evt <= e;
        @(posedge pclk);
        pwr_evt <= '0;
    endtask
endmodule

// [tb/tb.sv]
// Self-checking bench for the comparator and power control bank
`timescale 1ns/10ps
module tb;
    import cmp_misc_pkg::*;
    logic              pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic              cmp_raw, reg_rst, setpoint_load, cmp_irq, irq;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata, prdata, rd, seed, mexp, ctl;
    logic [3:0]        pstrb;
    pwr_evt_t          pwr_evt;
    ana_ctrl_t         ana_ctrl;
    int                n_errors, total_checks, cyc;

    cmp_misc_regs dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
        .pready, .pslverr, .cmp_raw, .pwr_evt, .ana_ctrl, .reg_rst, .setpoint_load, .cmp_irq, .irq);
    analog_partner u_ana (.pclk, .cmp_raw, .pwr_evt);

    always #12.5 pclk = ~pclk;
    // Hang guard
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_errors++;
            summarize();
        end
    end

    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction
    // Expected control word after a write with the given strobes
    function automatic logic [31:0] misc_exp(input logic [31:0] old, d, input logic [3:0] s);
        return (s[1:0] == 2'b11) ? ((d & 32'h30c) | 32'h10) : old;
    endfunction

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // One APB transfer, then one idle cycle
    task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [3:0] s);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        pstrb  <= s;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic summarize();
        if (n_errors == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        pclk    = 1'b0;
        presetn = 1'b0;
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = '0;
        pwdata  = '0;
        pstrb   = '0;
        seed    = 32'h0469911e;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(0, OFF_CMP_CTRL, 0, 4'hf);
        chk("cmp_ctrl_reset", 32'h0, rd);
        apb(0, OFF_MISC_CTRL, 0, 4'hf);
        chk("misc_reset", 32'h10, rd);
        mexp = 32'h10;
        apb(0, 12'h020, 0, 4'hf);
        chk("unmapped", 32'h1, {rd[30:0], err});
        // Random control words, partial strobes and power events
        for (int i = 0; i < 10; i++) begin
            seed = xs(seed);
            apb(1, OFF_MISC_CTRL, seed, {seed[11:10], seed[1], 1'b1});
            mexp = misc_exp(mexp, seed, {seed[11:10], seed[1], 1'b1});
            apb(0, OFF_MISC_CTRL, 0, 4'hf);
            chk("misc_rd", mexp, rd);
            chk("ana_ctrl", {mexp[9:8], mexp[3:2]}, ana_ctrl[3:0]);
            u_ana.pulse(pwr_evt_t'(seed[6:4]));
            #1;
            chk("reg_rst", seed[6] | (seed[5] & ~mexp[9]), reg_rst);
            chk("setpoint_load", seed[4] & ~mexp[9], setpoint_load);
            @(posedge pclk);
        end
        apb(1, OFF_INT_MASK, 32'h1, 4'hf);
        // Both edge selections: chosen edge, flag hold, clear, opposite edge
        for (int p = 0; p < 2; p++) begin
            ctl = 32'h41 | (p << 5);
            apb(1, OFF_CMP_CTRL, ctl, 4'hf);
            u_ana.set_level(p[0]);
            repeat (8) @(posedge pclk);
            apb(1, OFF_CMP_CTRL, ctl | 32'h8000, 4'hf);
            apb(1, OFF_INT_STAT, 32'h1, 4'hf);
            u_ana.set_level(!p[0]);
            repeat (8) @(posedge pclk);
            apb(0, OFF_CMP_CTRL, 0, 4'hf);
            chk("flag_set", ctl | 32'h8000 | ((1 - p) << 14), rd);
            chk("irqs_on", 32'h3, {cmp_irq, irq});
            apb(1, OFF_CMP_CTRL, ctl & 32'h21, 4'hf);
            apb(0, OFF_CMP_CTRL, 0, 4'hf);
            chk("flag_keep", (ctl & 32'h21) | 32'h8000 | ((1 - p) << 14), rd);
            chk("cmp_irq_off", 32'h0, cmp_irq);
            apb(1, OFF_CMP_CTRL, (ctl & 32'h21) | 32'h8000, 4'hf);
            apb(1, OFF_INT_STAT, 32'h1, 4'hf);
            u_ana.set_level(p[0]);
            repeat (8) @(posedge pclk);
            apb(0, OFF_CMP_CTRL, 0, 4'hf);
            chk("flag_clear", (ctl & 32'h21) | (p << 14), rd);
            chk("irq_clear", 32'h0, irq);
        end
        // Comparator off: edges leave the flag alone
        apb(1, OFF_CMP_CTRL, 32'h0, 4'hf);
        u_ana.set_level(1'b0);
        repeat (8) @(posedge pclk);
        u_ana.set_level(1'b1);
        repeat (8) @(posedge pclk);
        apb(0, OFF_CMP_CTRL, 0, 4'hf);
        chk("off_no_flag", 32'h0, rd & 32'hffffbfff);
        summarize();
    end
endmodule
